// File: dv/dbpc_stage_model.sv
`timescale 1ns/1ns
module dbpc_stage_model
  import dbpc_pkg::*;
(
  input wire logic hclk, // clock
  input wire dbpc_ana_t [1:0] ana, // power-stage controls from the block
  input wire logic [7:0] dly, // on cycles before the peak is reached
  output logic [1:0] peak_hit // comparator per channel
);
  logic [7:0] cnt [2];

  // two separate inductors, each ramping only while its switch is on
  always @(posedge hclk) begin
    for (int i = 0; i < 2; i++) begin
      cnt[i] <= ana[i].half_a ? cnt[i] + 8'h1 : 8'h0;
      peak_hit[i] <= ana[i].half_a && cnt[i] >= dly;
    end
  end
endmodule

// File: dv/dbpc_top_monitor.sv
`timescale 1ns/1ns
module dbpc_top_monitor
  import dbpc_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, low
  input wire logic [1:0] peak_hit, // comparator per channel
  input wire logic bat_uv, // undervoltage
  input wire dbpc_ana_t [1:0] ana // power-stage controls
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_blank_on0: assert property ($rose(ana[0].half_a) |-> ana[0].half_a [*3])
    else $error("switch 0 left on less than the blank time");
  chk_blank_on1: assert property ($rose(ana[1].half_a) |-> ana[1].half_a [*3])
    else $error("switch 1 left on less than the blank time");
  chk_min_off0: assert property ($fell(ana[0].half_a) |-> !ana[0].half_a [*2])
    else $error("switch 0 off time below minimum");
  chk_min_off1: assert property ($fell(ana[1].half_a) |-> !ana[1].half_a [*2])
    else $error("switch 1 off time below minimum");
  chk_half_pair0: assert property (ana[0].half_b |-> ana[0].half_a)
    else $error("channel 0 second half on alone");
  chk_half_pair1: assert property (ana[1].half_b |-> ana[1].half_a)
    else $error("channel 1 second half on alone");
  chk_peak_end0: assert property ((ana[0].half_a && peak_hit[0]) [*3] |=> !ana[0].half_a)
    else $error("switch 0 still on after peak reached");
  chk_peak_end1: assert property ((ana[1].half_a && peak_hit[1]) [*3] |=> !ana[1].half_a)
    else $error("switch 1 still on after peak reached");
  chk_uv_halt: assert property (bat_uv [*6] |-> !ana[0].half_a && !ana[1].half_a)
    else $error("switching during undervoltage");
endmodule

bind dbpc_top dbpc_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .peak_hit(peak_hit),
  .bat_uv(bat_uv), .ana(ana));

// File: dv/dual_buck_peak_current_control_test.sv
`timescale 1ns/1ns
`include "dbpc_regs.svh"
module dual_buck_peak_current_control_test;
  import dbpc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq;
  logic bat_uv = 1'b0;
  logic dim_pin = 1'b0;
  logic [1:0] peak_hit;
  logic [1:0] short_det = 2'h0;
  logic [7:0] dly = 8'h0;
  dbpc_ana_t [1:0] ana;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #50 hclk = ~hclk;

  dbpc_top #(.STARTUP_CYC(20), .DEACT_CYC(40)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .peak_hit(peak_hit), .short_det(short_det), .dim_pin(dim_pin),
    .bat_uv(bat_uv), .ana(ana), .irq(irq));
  dbpc_stage_model u_stage (.hclk(hclk), .ana(ana), .dly(dly), .peak_hit(peak_hit));

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ready and data are read mid-cycle, so they are the values seen at the next edge
  task wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x & m, e, s);
  endtask

  task sc_regs;
    rd_chk(`DBPC_OFF_CTRL3, 32'hffffffff, `DBPC_RST_CTRL3, "ctrl3 reset");
    rd_chk(`DBPC_OFF_CTRL1, 32'hffffffff, 32'h0, "ctrl1 reset");
    rd_chk(8'h1c, 32'hffffffff, 32'h0, "unmapped read");
    wr(`DBPC_OFF_CTRL2, 32'h00ad5000);
    wr(`DBPC_OFF_CTRL3, 32'h0000c024);
    rd_chk(`DBPC_OFF_CTRL2, 32'hffffffff, 32'h00ad5000, "ctrl2 readback");
    check(32'(ana[0].peak), 32'h2b, "peak 0");
    check(32'(ana[1].peak), 32'h15, "peak 1");
    check(32'(ana[0].win), 32'h2, "window 0");
    check(32'(ana[1].win), 32'h1, "window 1");
    check(32'(hresp), 32'h0, "okay response");
  endtask

  task act_step(input logic [1:0] code, input logic dim, input logic [9:0] duty, input logic e);
    int n0;
    int n1;
    dim_pin <= dim;
    wr(`DBPC_OFF_DUTY, {6'h0, duty, 6'h0, 10'h0});
    wr(`DBPC_OFF_CTRL3, {16'h0, 2'b11, code, 6'h0, 6'h24});
    repeat (30) @(posedge hclk);
    n0 = 0;
    n1 = 0;
    repeat (60) begin
      @(negedge hclk);
      n0 += int'(ana[0].half_a);
      n1 += int'(ana[1].half_a);
    end
    @(posedge hclk);
    check(32'(n1 > 0), 32'(e), "channel 1 activity");
    check(32'(n0 > 0), 32'(dim), "channel 0 follows pin");
  endtask

  task sc_acts;
    act_step(2'b00, 1'b1, 10'h000, 1'b0);
    act_step(2'b01, 1'b1, 10'h000, 1'b0);
    act_step(2'b01, 1'b0, 10'h3ff, 1'b1);
    act_step(2'b10, 1'b0, 10'h000, 1'b1);
    act_step(2'b11, 1'b1, 10'h000, 1'b1);
    act_step(2'b11, 1'b0, 10'h000, 1'b0);
  endtask

  task meas(output int on_n, output int off_n, output logic hb);
    do @(negedge hclk); while (!ana[0].half_a);
    do @(negedge hclk); while (ana[0].half_a);
    off_n = 0;
    while (!ana[0].half_a) begin
      off_n++;
      @(negedge hclk);
    end
    on_n = 0;
    hb = ana[0].half_b;
    while (ana[0].half_a) begin
      on_n++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask

  task time_step(input logic [1:0] rds, input logic [3:0] vt, input logic [7:0] d);
    int on_n;
    int off_n;
    int lo;
    logic hb;
    wr(`DBPC_OFF_CTRL1, {28'h0, rds, 2'b00});
    wr(`DBPC_OFF_CTRL2, {8'h0, 6'h2b, 6'h15, vt, 4'h0, 4'h0});
    dly <= d;
    meas(on_n, off_n, hb);
    meas(on_n, off_n, hb);
    lo = (int'(d) + 2 > 3) ? int'(d) + 2 : 3;
    check(32'(off_n), 32'((int'(vt) + 1) * 5), "off time");
    check(32'(on_n >= lo && on_n <= int'(d) + 6), 32'h1, "on time");
    check(32'(hb), 32'(rds != 2'b00), "second half");
  endtask

  task sc_timing;
    wr(`DBPC_OFF_CTRL3, 32'h00008024);
    time_step(2'b00, 4'h0, 8'd0);
    time_step(2'b01, 4'h3, 8'd10);
    time_step(2'b10, 4'hf, 8'd4);
    time_step(2'b11, 4'h7, 8'd0);
  endtask

  // pulse a short on channel 0, then read the latch and clear it with start-up done
  task probe(input logic es, input logic ei);
    short_det[0] <= 1'b1;
    repeat (6) @(posedge hclk);
    short_det[0] <= 1'b0;
    repeat (4) @(posedge hclk);
    rd_chk(`DBPC_OFF_STAT, 32'h1, 32'(es), "short latch");
    check(32'(irq), 32'(ei), "interrupt level");
    wr(`DBPC_OFF_STAT, 32'h5);
  endtask

  task sc_short;
    wr(`DBPC_OFF_MASK, 32'h1);
    rd_chk(`DBPC_OFF_STAT, 32'h4, 32'h4, "start-up done");
    probe(1'b1, 1'b1);
    probe(1'b0, 1'b0);
    repeat (40) @(posedge hclk);
    rd_chk(`DBPC_OFF_STAT, 32'h5, 32'h4, "start-up ended");
    probe(1'b1, 1'b1);
    repeat (40) @(posedge hclk);
    bat_uv <= 1'b1;
    repeat (8) @(posedge hclk);
    check(32'(ana[0].half_a), 32'h0, "halt in undervoltage");
    bat_uv <= 1'b0;
    probe(1'b0, 1'b0);
    repeat (40) @(posedge hclk);
    wr(`DBPC_OFF_CTRL3, 32'h00000024);
    repeat (50) @(posedge hclk);
    wr(`DBPC_OFF_CTRL3, 32'h00008024);
    probe(1'b0, 1'b0);
    repeat (40) @(posedge hclk);
    wr(`DBPC_OFF_MASK, 32'h0);
    probe(1'b1, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    sc_regs;
    sc_acts;
    sc_timing;
    sc_short;
    finish_test;
  end
endmodule

// File: pkg/dbpc_pkg.sv
package dbpc_pkg;

  localparam int TMR_W = 8;
  localparam int LONG_W = 20;
  localparam int DUTY_W = 10;

  typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF} dbpc_phase_t;

  // activation field encodings
  typedef enum logic [1:0] {ACT_OFF, ACT_PWM, ACT_ON, ACT_PIN} dbpc_act_t;

  // per-channel view handed to the power stage
  typedef struct packed {
    logic half_a;
    logic half_b;
    logic [5:0] peak;
    logic [1:0] win;
  } dbpc_ana_t;

  // per-channel sequencing state
  typedef struct packed {
    dbpc_phase_t ph;
    logic [TMR_W-1:0] tmr;
    logic [LONG_W-1:0] su;
    logic [LONG_W-1:0] offc;
    logic need_su;
    logic latched;
    logic half_a;
    logic half_b;
  } dbpc_ch_t;

  // whole state of the top module
  typedef struct packed {
    logic dp_v;
    logic dp_w;
    logic [7:0] dp_a;
    logic rd_done;
    logic [31:0] hrdata;
    logic [31:0] ctrl1;
    logic [31:0] ctrl2;
    logic [31:0] ctrl3;
    logic [31:0] duty;
    logic [3:0] stat;
    logic [3:0] mask;
    logic irq;
    logic uv_prev;
    dbpc_ch_t [1:0] ch;
  } dbpc_state_t;

endpackage

// File: pkg/dbpc_regs.svh
`ifndef DBPC_REGS_SVH
`define DBPC_REGS_SVH

// clock period of hclk
`define DBPC_CLK_NS 100

// register byte offsets
`define DBPC_OFF_CTRL1 8'h00
`define DBPC_OFF_CTRL2 8'h04
`define DBPC_OFF_CTRL3 8'h08
`define DBPC_OFF_DUTY 8'h0c
`define DBPC_OFF_STAT 8'h10
`define DBPC_OFF_MASK 8'h14
`define DBPC_OFF_STATE 8'h18

// first_control_word fields
`define DBPC_RES_MODE_LSB 2
// second_control_word fields
`define DBPC_PK0_LSB 18
`define DBPC_PK1_LSB 12
`define DBPC_VT0_LSB 8
`define DBPC_VT1_LSB 4
// third_control_word fields
`define DBPC_WIN0_LSB 4
`define DBPC_WIN1_LSB 2
`define DBPC_ACT0_LSB 14
`define DBPC_ACT1_LSB 12
// duty register fields
`define DBPC_DUTY0_LSB 0
`define DBPC_DUTY1_LSB 16
// status / mask fields
`define DBPC_STAT_SHORT_LSB 0
`define DBPC_STAT_SUDONE_LSB 2

// reset values: channel 0 follows the dimming pin, channel 1 off
`define DBPC_RST_CTRL1 32'h0000_0000
`define DBPC_RST_CTRL2 32'h0000_0000
`define DBPC_RST_CTRL3 32'h0000_c000
`define DBPC_RST_DUTY 32'h0000_0000
`define DBPC_RST_MASK 32'h0000_0000

// times in their own unit
`define DBPC_BLANK_NS 300
`define DBPC_TOFF_MIN_NS 200
`define DBPC_TOFF_STEP_NS 500
`define DBPC_STARTUP_US 5000
`define DBPC_DEACT_US 10000

// cycle counts: least times round up
`define DBPC_BLANK_CYC ((`DBPC_BLANK_NS + `DBPC_CLK_NS - 1) / `DBPC_CLK_NS)
`define DBPC_TOFF_MIN_CYC ((`DBPC_TOFF_MIN_NS + `DBPC_CLK_NS - 1) / `DBPC_CLK_NS)
`define DBPC_TOFF_STEP_CYC ((`DBPC_TOFF_STEP_NS + `DBPC_CLK_NS - 1) / `DBPC_CLK_NS)
`define DBPC_STARTUP_CYC (`DBPC_STARTUP_US * 1000 / `DBPC_CLK_NS)
`define DBPC_DEACT_CYC (`DBPC_DEACT_US * 1000 / `DBPC_CLK_NS)

`endif

// File: rtl/dbpc_pwm.sv
`timescale 1ns/1ns
module dbpc_pwm #(
  parameter int DW = 10
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, low
  input wire logic [1:0][DW-1:0] duty, // on-count per channel
  output logic [1:0] pwm // dimming level per channel
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic [1:0] pwm;
  } dbpc_pwm_reg_t;

  dbpc_pwm_reg_t q, d;

  generate
    if (DW < 2 || DW > 16) begin : g_chk
      $error("dbpc_pwm: resolution out of range");
    end
  endgenerate

  always_comb begin
    d = q;
    d.cnt = q.cnt + 1'b1;
    for (int i = 0; i < 2; i++) begin
      d.pwm[i] = (q.cnt < duty[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pwm = q.pwm;
endmodule

// File: rtl/dbpc_sync.sv
`timescale 1ns/1ns
module dbpc_sync #(
  parameter int W = 1
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, low
  input wire logic [W-1:0] din, // asynchronous levels
  output logic [W-1:0] dout // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dbpc_sync_reg_t;

  dbpc_sync_reg_t q, d;

  generate
    if (W < 1) begin : g_chk
      $error("dbpc_sync: width must be positive");
    end
  endgenerate

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule

// File: rtl/dbpc_top.sv
`timescale 1ns/1ns
`include "dbpc_regs.svh"

// Function
// - two buck channels run independently, each regulating peak current with a fixed off-time.
// - a two-bit field of the first control word picks one or both power-stage halves.
// - the reachable peak range follows the resistance mode, lower in the one-half mode.
// - each channel takes its peak target from its own six-bit field of the second word.
// - each channel takes its off-time constant from its own four-bit field of the second word.
// - each period starts with the switch on, and the peak indication turns it off.
// - after turn-off the switch stays off for the derived off-time before the next period.
// - the switch stays on for the blank interval whatever the peak indication says.
// - every cycle keeps at least the minimum off-time so the bootstrap can recharge.
// - each channel has a two-bit input-voltage window field in the third word.
// - during the start-up window a shorted output is not reported for that channel.
// - start-up is armed at first use after reset, after long idle, after clear and after undervoltage.
// - dimming comes from the pin or from a 10-bit internal generator.
// - activation codes are off, internal generator, always on and dimming pin.
module dbpc_top
  import dbpc_pkg::*;
#(
  parameter int STARTUP_CYC = `DBPC_STARTUP_CYC,
  parameter int DEACT_CYC = `DBPC_DEACT_CYC,
  parameter int DW = DUTY_W
) (
  input wire logic hclk, // bus and control clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic [1:0] peak_hit, // comparator: peak reached
  input wire logic [1:0] short_det, // output short to ground seen
  input wire logic dim_pin, // direct dimming input
  input wire logic bat_uv, // battery_supply undervoltage
  output dbpc_ana_t [1:0] ana, // per-channel power-stage controls
  output logic irq // interrupt level
);

  localparam logic [LONG_W-1:0] SU_LD = LONG_W'(STARTUP_CYC);
  localparam logic [LONG_W-1:0] DEACT_LD = LONG_W'(DEACT_CYC);
  localparam logic [TMR_W-1:0] BLANK_C = TMR_W'(`DBPC_BLANK_CYC);
  localparam logic [TMR_W-1:0] TOFF_MIN_C = TMR_W'(`DBPC_TOFF_MIN_CYC);
  localparam logic [TMR_W-1:0] TOFF_STEP_C = TMR_W'(`DBPC_TOFF_STEP_CYC);

  generate
    if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << LONG_W)) begin : g_chk_su
      $error("dbpc_top: start-up count out of range");
    end
    if (DEACT_CYC < 1 || DEACT_CYC >= (1 << LONG_W)) begin : g_chk_dly
      $error("dbpc_top: deactivation count out of range");
    end
    if (DW != DUTY_W) begin : g_chk_dw
      $error("dbpc_top: dimming resolution must be ten bits");
    end
    if (16 * `DBPC_TOFF_STEP_CYC >= (1 << TMR_W)) begin : g_chk_toff
      $error("dbpc_top: off-time does not fit its timer");
    end
    if (`DBPC_TOFF_STEP_CYC < 1) begin : g_chk_step
      $error("dbpc_top: off-time step must be at least one cycle");
    end
    if (`DBPC_BLANK_CYC < 1 || `DBPC_BLANK_CYC >= (1 << TMR_W)) begin : g_chk_blank
      $error("dbpc_top: blank interval does not fit its timer");
    end
    if (`DBPC_TOFF_MIN_CYC < 1 || `DBPC_TOFF_MIN_CYC >= (1 << TMR_W)) begin : g_chk_tmin
      $error("dbpc_top: minimum off-time does not fit its timer");
    end
  endgenerate

  dbpc_state_t q, d;

  logic [5:0] sync_out;
  logic [1:0] peak_s;
  logic [1:0] short_s;
  logic dim_s;
  logic uv_s;
  logic [1:0] pwm_lvl;
  logic [1:0][DW-1:0] duty_w;

  // every pin input passes two flops before use: comparator and fault lines
  // move with no regard to hclk, and a metastable level must not split the phase logic
  dbpc_sync #(.W(6)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({bat_uv, dim_pin, short_det, peak_hit}),
    .dout(sync_out)
  );

  assign peak_s = sync_out[1:0];
  assign short_s = sync_out[3:2];
  assign dim_s = sync_out[4];
  assign uv_s = sync_out[5];

  assign duty_w[0] = q.duty[`DBPC_DUTY0_LSB +: DW];
  assign duty_w[1] = q.duty[`DBPC_DUTY1_LSB +: DW];

  // one shared counter keeps the dimming periods of both channels aligned
  dbpc_pwm #(.DW(DW)) u_pwm (
    .hclk(hclk),
    .hresetn(hresetn),
    .duty(duty_w),
    .pwm(pwm_lvl)
  );

  // address decode for the write data phase
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      `DBPC_OFF_CTRL1, `DBPC_OFF_CTRL2, `DBPC_OFF_CTRL3, `DBPC_OFF_DUTY,
      `DBPC_OFF_STAT, `DBPC_OFF_MASK, `DBPC_OFF_STATE: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // activation code to dimming level
  function automatic logic act_level(input logic [1:0] code, input logic pwm,
                                     input logic pin);
    case (dbpc_act_t'(code))
      ACT_OFF: act_level = 1'b0;
      ACT_PWM: act_level = pwm;
      ACT_ON: act_level = 1'b1;
      ACT_PIN: act_level = pin;
      default: act_level = 1'b0;
    endcase
  endfunction

  // off-time from the constant, never below the minimum
  function automatic logic [TMR_W-1:0] toff_cyc(input logic [3:0] vt);
    logic [TMR_W-1:0] t;
    t = TMR_W'({4'h0, vt} + 8'h01) * TOFF_STEP_C;
    toff_cyc = (t < TOFF_MIN_C) ? TOFF_MIN_C : t;
  endfunction

  function automatic logic [3:0] ch_vt(input logic [31:0] c2, input int i);
    ch_vt = (i == 0) ? c2[`DBPC_VT0_LSB +: 4] : c2[`DBPC_VT1_LSB +: 4];
  endfunction

  function automatic logic [5:0] ch_peak(input logic [31:0] c2, input int i);
    ch_peak = (i == 0) ? c2[`DBPC_PK0_LSB +: 6] : c2[`DBPC_PK1_LSB +: 6];
  endfunction

  function automatic logic [1:0] ch_act(input logic [31:0] c3, input int i);
    ch_act = (i == 0) ? c3[`DBPC_ACT0_LSB +: 2] : c3[`DBPC_ACT1_LSB +: 2];
  endfunction

  function automatic logic [1:0] ch_win(input logic [31:0] c3, input int i);
    ch_win = (i == 0) ? c3[`DBPC_WIN0_LSB +: 2] : c3[`DBPC_WIN1_LSB +: 2];
  endfunction

  function automatic logic [31:0] read_mux(input dbpc_state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (s.dp_a)
      `DBPC_OFF_CTRL1: r = s.ctrl1;
      `DBPC_OFF_CTRL2: r = s.ctrl2;
      `DBPC_OFF_CTRL3: r = s.ctrl3;
      `DBPC_OFF_DUTY: r = s.duty;
      `DBPC_OFF_STAT: r = {28'h0, s.stat};
      `DBPC_OFF_MASK: r = {28'h0, s.mask};
      `DBPC_OFF_STATE: begin
        for (int i = 0; i < 2; i++) begin
          r[i * 8 +: 2] = s.ch[i].ph;
          r[i * 8 + 2] = (s.ch[i].su != '0);
          r[i * 8 + 3] = s.ch[i].latched;
          r[i * 8 + 4] = s.ch[i].need_su;
        end
        r[16] = s.uv_prev;
      end
      default: r = 32'h0000_0000;
    endcase
    read_mux = r;
  endfunction

  always_comb begin
    logic [3:0] stat_set;
    logic [3:0] stat_clr;
    logic en;
    logic low_r;
    d = q;
    stat_set = 4'h0;
    stat_clr = 4'h0;
    en = 1'b0;
    low_r = 1'b0;

    // data phase: writes take one cycle, reads one wait state
    // read data comes from a flop so the mux never sits in the bus return path
    if (q.dp_v && q.dp_w && reg_hit(q.dp_a)) begin
      case (q.dp_a)
        `DBPC_OFF_CTRL1: d.ctrl1 = hwdata;
        `DBPC_OFF_CTRL2: d.ctrl2 = hwdata;
        `DBPC_OFF_CTRL3: d.ctrl3 = hwdata;
        `DBPC_OFF_DUTY: d.duty = hwdata;
        `DBPC_OFF_STAT: stat_clr = hwdata[3:0];
        `DBPC_OFF_MASK: d.mask = hwdata[3:0];
        default: d.ctrl1 = q.ctrl1;
      endcase
    end
    if (q.dp_v && !q.dp_w && !q.rd_done) begin
      d.hrdata = read_mux(q);
      d.rd_done = 1'b1;
    end

    // address phase
    if (hready) begin
      d.dp_v = hsel && htrans[1];
      d.dp_w = hwrite;
      d.dp_a = haddr[7:0];
      d.rd_done = 1'b0;
    end

    d.uv_prev = uv_s;
    // code 00 drives one half of the stage, any other code both
    low_r = (q.ctrl1[`DBPC_RES_MODE_LSB +: 2] != 2'b00);

    for (int i = 0; i < 2; i++) begin
      // enable is the dimming level, blocked by a latched fault or a low supply
      en = act_level(ch_act(q.ctrl3, i), pwm_lvl[i], dim_s)
           && !q.ch[i].latched && !uv_s;

      // start-up arming and the idle timer
      if (uv_s && !q.uv_prev) begin
        d.ch[i].need_su = 1'b1;
      end
      if (!en) begin
        if (q.ch[i].offc == DEACT_LD - 1'b1) begin
          d.ch[i].need_su = 1'b1;
        end
        // the idle count saturates so one long idle arms start-up only once
        if (q.ch[i].offc < DEACT_LD) begin
          d.ch[i].offc = q.ch[i].offc + 1'b1;
        end
      end else begin
        d.ch[i].offc = '0;
      end
      if (q.ch[i].su != '0) begin
        d.ch[i].su = q.ch[i].su - 1'b1;
        if (q.ch[i].su == LONG_W'(1)) begin
          stat_set[`DBPC_STAT_SUDONE_LSB + i] = 1'b1;
        end
      end
      if (en && q.ch[i].need_su) begin
        d.ch[i].su = SU_LD;
        d.ch[i].need_su = 1'b0;
      end

      // short to ground, blind during start-up
      if (short_s[i] && en && q.ch[i].su == '0 && !q.ch[i].need_su &&
          q.ch[i].ph != PH_IDLE) begin
        d.ch[i].latched = 1'b1;
        stat_set[`DBPC_STAT_SHORT_LSB + i] = 1'b1;
      end
      // a write-one clear of a latched-off channel re-arms start-up
      if (stat_clr[`DBPC_STAT_SHORT_LSB + i] && q.ch[i].latched &&
          !stat_set[`DBPC_STAT_SHORT_LSB + i]) begin
        d.ch[i].latched = 1'b0;
        d.ch[i].need_su = 1'b1;
      end

      // switching sequence
      case (q.ch[i].ph)
        PH_IDLE: begin
          if (en) begin
            d.ch[i].ph = PH_ON;
            d.ch[i].tmr = '0;
          end
        end
        PH_ON: begin
          if (q.ch[i].tmr < BLANK_C) begin
            d.ch[i].tmr = q.ch[i].tmr + 1'b1;
          end
          // neither a peak nor a disable ends the on-phase inside the blank interval
          if (q.ch[i].tmr >= BLANK_C - 1'b1) begin
            if (!en) begin
              // a disable still leaves the bootstrap its minimum recharge time
              d.ch[i].ph = PH_OFF;
              d.ch[i].tmr = TOFF_MIN_C;
            end else if (peak_s[i]) begin
              d.ch[i].ph = PH_OFF;
              d.ch[i].tmr = toff_cyc(ch_vt(q.ctrl2, i));
            end
          end
        end
        PH_OFF: begin
          d.ch[i].tmr = q.ch[i].tmr - 1'b1;
          if (q.ch[i].tmr <= TMR_W'(1)) begin
            d.ch[i].ph = en ? PH_ON : PH_IDLE;
            d.ch[i].tmr = '0;
          end
        end
        default: begin
          d.ch[i].ph = PH_IDLE;
          d.ch[i].tmr = '0;
        end
      endcase

      // the second half only follows the first, it never switches alone
      d.ch[i].half_a = (d.ch[i].ph == PH_ON);
      d.ch[i].half_b = (d.ch[i].ph == PH_ON) && low_r;
    end

    // sticky status, set beats clear
    // a short seen in the cycle of its clear stays latched and reported
    d.stat = (q.stat & ~stat_clr) | stat_set;
    d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.ctrl1 <= `DBPC_RST_CTRL1;
      q.ctrl2 <= `DBPC_RST_CTRL2;
      q.ctrl3 <= `DBPC_RST_CTRL3;
      q.duty <= `DBPC_RST_DUTY;
      q.mask <= 4'(`DBPC_RST_MASK);
      q.ch[0].need_su <= 1'b1;
      q.ch[1].need_su <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // only a read data phase waits, and only until its word is in the flop
  assign hreadyout = !(q.dp_v && !q.dp_w && !q.rd_done);
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign irq = q.irq;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ana
      assign ana[g].half_a = q.ch[g].half_a;
      assign ana[g].half_b = q.ch[g].half_b;
      assign ana[g].peak = ch_peak(q.ctrl2, g);
      assign ana[g].win = ch_win(q.ctrl3, g);
    end
  endgenerate

endmodule
